/* design/tcc_chan_ctrl.sv */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// R1: Output channel flag sets on compare match
// R2: Compare above reload flags on overflow/underflow
// R3: Input capture sets flag; clear by read
// R4: Update flag on wrap when repetition zero
// R5: Soft or trigger reinit flags unless restricted
// R6: Event bits written one, self-clear, zero ignored
// R7: Break strobe clears output enable, sets flag
// R8: Trigger strobe sets trigger flag
// R9: Control strobe updates only with preload select
// R10: Channel strobe on output sets flag
// R11: Channel strobe on input captures, overcapture
// R12: Update strobe reloads counter and prescaler
// R13: Selection decodes output, input one/two/trigger
// R14: Selection writable only while channel disabled
// R15: Clear enable drives reference low on trigger
// R16: Modes frozen, set, clear, toggle, force
// R17: PWM one and two levels by direction
// R18: Lock level three freezes mode, preload
// R19: PWM reference changes only on compare change; the code also moves it after frozen mode and on a fast hit
// R20: Preload selects shadow compare, moved on update
// R21: Software uses preload with PWM mode
// R22: Fast enable acts as match in three
// R23: Software clears flags by writing zero
// R24: Event register reads as zero
module tcc_chan_ctrl #(
    parameter int CW            = 16,
    parameter bit HAS_COMPL_OUT = 1'b1
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    input  wire logic [CW-1:0]     counter_value,
    input  wire logic [CW-1:0]     auto_reload_value,
    input  wire logic              count_down,
    input  wire logic [1:0]        center_align_select,
    input  wire logic              counter_wrap,
    input  wire logic              rep_count_zero,
    input  wire logic              update_disable,
    input  wire logic              update_source_restrict,
    input  wire logic              trigger_reinit,
    input  wire logic              trigger_edge,
    input  wire logic              chan0_enable,
    input  wire logic              chan1_enable,
    input  wire logic              control_preload_select,
    input  wire logic              lock_level3,
    input  wire logic              int_trig_selected,
    input  wire logic              capture_edge,
    input  wire logic              filtered_external_trigger,
    input  wire logic              timer_input_one,
    input  wire logic              timer_input_two,
    input  wire logic              internal_trigger_source,
    output logic                   chan0_output_reference,
    output logic                   chan0_capture_input,
    output logic                   main_output_enable_clr,
    output logic                   control_update_event,
    output logic                   update_event,
    output logic                   counter_reload,
    output logic [CW-1:0]          counter_load_value,
    output logic [15:0]            status_flags
);
    import tcc_pkg::*;

    logic [7:0]    strobe_q;
    logic [15:0]   mode_q;
    logic [15:0]   status_q;
    logic [CW-1:0] cmp_pre_q;
    logic [CW-1:0] cmp_act_q;
    logic          ref_q;
    logic          pwm_lvl_q;
    logic [2:0]    omode_prev_q;
    logic [1:0]    trig_pipe_q;
    logic [2:0]    pin_s1_q;
    logic [2:0]    pin_s2_q;
    logic [15:0]   rdata_q;
    logic          moe_clr_q;
    logic          com_ev_q;
    logic          upd_ev_q;
    logic          reload_q;
    logic [CW-1:0] load_val_q;

    tcc_sel_t      sel0;
    tcc_omode_t    omode;
    logic          is_output;
    logic          preload_on;
    logic          wr_mode;
    logic          wr_cmp;
    logic          rd_cmp;
    logic          center;
    logic          match;
    logic          cmp_event;
    logic          sw_chan_ev;
    logic          capture;
    logic          upd_wrap;
    logic          upd_soft;
    logic          upd_any;
    logic          pwm_lvl;
    logic          fast_hit;
    logic          etr_clear;
    logic          ref_d;

    assign sel0       = tcc_sel_t'(mode_q[MD_SEL_LSB +: 2]);
    assign omode      = tcc_omode_t'(mode_q[MD_MODE_LSB +: 3]);
    assign is_output  = (sel0 == TCC_SEL_OUTPUT);
    assign preload_on = mode_q[MD_PRELOAD];
    assign wr_mode    = reg_wr && (reg_addr == MODE_LOW_OFS);
    assign wr_cmp     = reg_wr && (reg_addr == COMPARE0_OFS);
    assign rd_cmp     = reg_rd && (reg_addr == COMPARE0_OFS);
    assign center     = (center_align_select != 2'b00);

    // Software strobes: only ones are latched, held a single cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strobe_q <= 8'h00;
        end else if (reg_wr && (reg_addr == EVENT_OFS)) begin
            strobe_q <= reg_wdata[7:0];  // [R6]
        end else begin
            strobe_q <= 8'h00;  // [R6]
        end
    end

    // Update sources; a disabled update also suppresses preload transfer
    assign upd_wrap = counter_wrap && rep_count_zero && !update_disable;  // [R4]
    assign upd_soft = (strobe_q[EV_UPDATE] || trigger_reinit) && !update_disable;
    assign upd_any  = upd_wrap || upd_soft;

    // Match: above-reload compare only fires on wrap; center exceptions live in the counter core
    assign match      = is_output && ((cmp_act_q > auto_reload_value) ? counter_wrap  // [R2]
                                       : (counter_value == cmp_act_q));  // [R1]
    assign sw_chan_ev = strobe_q[EV_CHAN0];
    assign cmp_event  = match || (sw_chan_ev && is_output);  // [R10]
    assign capture    = !is_output && (capture_edge || sw_chan_ev);  // [R3] [R11]

    // Mode register: selection gated by enable, mode/preload gated by lock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_q <= MODE_RST;
        end else if (wr_mode) begin
            if (!chan0_enable) begin
                mode_q[MD_SEL_LSB +: 2] <= reg_wdata[MD_SEL_LSB +: 2];  // [R14]
            end
            if (!(lock_level3 && is_output)) begin
                mode_q[MD_MODE_LSB +: 3] <= reg_wdata[MD_MODE_LSB +: 3];  // [R18]
                mode_q[MD_PRELOAD]       <= reg_wdata[MD_PRELOAD];  // [R18]
            end
            mode_q[MD_FAST]  <= reg_wdata[MD_FAST];
            mode_q[MD_CLEAR] <= reg_wdata[MD_CLEAR];
            if (!chan1_enable) begin
                mode_q[MD_SEL1_LSB +: 2] <= reg_wdata[MD_SEL1_LSB +: 2];
            end
            mode_q[15:10] <= reg_wdata[15:10];
        end
    end

    // Compare shadow and active copies; capture loads both so reads see it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmp_pre_q <= COMPARE_RST[CW-1:0];
            cmp_act_q <= COMPARE_RST[CW-1:0];
        end else if (capture) begin
            cmp_pre_q <= counter_value;  // [R11]
            cmp_act_q <= counter_value;  // [R11]
        end else begin
            if (wr_cmp) begin
                cmp_pre_q <= reg_wdata[CW-1:0];  // [R20]
            end
            if (wr_cmp && !preload_on) begin
                cmp_act_q <= reg_wdata[CW-1:0];  // [R20]
            end else if (upd_any && preload_on) begin
                cmp_act_q <= wr_cmp ? reg_wdata[CW-1:0] : cmp_pre_q;  // [R20]
            end
        end
    end

    // Sticky flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_q <= STATUS_RST;
        end else begin
            if (reg_wr && (reg_addr == STATUS_OFS)) begin
                status_q[ST_UPDATE]   <= status_q[ST_UPDATE] & reg_wdata[ST_UPDATE];  // [R23]
                status_q[ST_CHAN0]    <= status_q[ST_CHAN0] & reg_wdata[ST_CHAN0];  // [R23]
                status_q[ST_CONTROL]  <= status_q[ST_CONTROL] & reg_wdata[ST_CONTROL];
                status_q[ST_TRIGGER]  <= status_q[ST_TRIGGER] & reg_wdata[ST_TRIGGER];
                status_q[ST_BREAK]    <= status_q[ST_BREAK] & reg_wdata[ST_BREAK];
                status_q[ST_OVERCAP0] <= status_q[ST_OVERCAP0] & reg_wdata[ST_OVERCAP0];
            end
            if (rd_cmp && !is_output) begin
                status_q[ST_CHAN0] <= 1'b0;  // [R3]
            end
            if (upd_wrap || (upd_soft && !update_source_restrict)) begin
                status_q[ST_UPDATE] <= 1'b1;  // [R4] [R5]
            end
            if (cmp_event || capture) begin
                status_q[ST_CHAN0] <= 1'b1;  // [R1] [R3] [R10]
            end
            if (capture && status_q[ST_CHAN0]) begin
                status_q[ST_OVERCAP0] <= 1'b1;  // [R11]
            end
            if (com_ev_q) begin
                status_q[ST_CONTROL] <= 1'b1;
            end
            if (strobe_q[EV_TRIGGER]) begin
                status_q[ST_TRIGGER] <= 1'b1;  // [R8]
            end
            if (strobe_q[EV_BREAK]) begin
                status_q[ST_BREAK] <= 1'b1;  // [R7]
            end
        end
    end

    // Event pulses toward the counter core and output stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            moe_clr_q  <= 1'b0;
            com_ev_q   <= 1'b0;
            upd_ev_q   <= 1'b0;
            reload_q   <= 1'b0;
            load_val_q <= '0;
        end else begin
            moe_clr_q <= strobe_q[EV_BREAK];  // [R7]
            com_ev_q  <= strobe_q[EV_CONTROL] && control_preload_select && HAS_COMPL_OUT;  // [R9]
            upd_ev_q  <= upd_any;
            reload_q  <= upd_soft;  // [R12]
            if (upd_soft) begin
                load_val_q <= (center || !count_down) ? '0 : auto_reload_value;  // [R12]
            end
        end
    end

    // Pin inputs crossing into the timer clock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_s1_q <= 3'b000;
            pin_s2_q <= 3'b000;
        end else begin
            pin_s1_q <= {internal_trigger_source, timer_input_two, timer_input_one};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Capture source decode; trigger source is dead without an internal trigger
    logic cap_in_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cap_in_q <= 1'b0;
        end else begin
            unique case (sel0)
                TCC_SEL_OUTPUT: cap_in_q <= 1'b0;  // [R13]
                TCC_SEL_IN_ONE: cap_in_q <= pin_s2_q[0];  // [R13]
                TCC_SEL_IN_TWO: cap_in_q <= pin_s2_q[1];  // [R13]
                TCC_SEL_IN_TRG: cap_in_q <= pin_s2_q[2] && int_trig_selected;  // [R13]
            endcase
        end
    end

    // PWM level from the live comparison and count direction
    always_comb begin
        if (count_down) begin
            pwm_lvl = (counter_value <= cmp_act_q);  // [R17]
        end else begin
            pwm_lvl = (counter_value < cmp_act_q);  // [R17]
        end
        if (omode == TCC_OM_PWM_TWO) begin
            pwm_lvl = !pwm_lvl;  // [R17]
        end
    end

    // Fast path: trigger edge treated as a match after a fixed pipeline
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trig_pipe_q <= 2'b00;
        end else begin
            trig_pipe_q <= {trig_pipe_q[0], trigger_edge};
        end
    end
    assign fast_hit  = trig_pipe_q[FAST_TRIG_CYC-2] && mode_q[MD_FAST] && omode[2] && omode[1];  // [R22]
    assign etr_clear = mode_q[MD_CLEAR] && filtered_external_trigger;  // [R15]

    // Reference level; PWM only moves when the comparison moves, the previous mode was frozen, or the fast path hits
    always_comb begin
        ref_d = ref_q;
        unique case (omode)
            TCC_OM_FROZEN:  ref_d = ref_q;  // [R16]
            TCC_OM_SET:     ref_d = match ? 1'b1 : ref_q;  // [R16]
            TCC_OM_CLEAR:   ref_d = match ? 1'b0 : ref_q;  // [R16]
            TCC_OM_TOGGLE:  ref_d = match ? !ref_q : ref_q;  // [R16]
            TCC_OM_FORCE_L: ref_d = 1'b0;  // [R16]
            TCC_OM_FORCE_H: ref_d = 1'b1;  // [R16]
            TCC_OM_PWM_ONE,
            TCC_OM_PWM_TWO: begin
                if ((pwm_lvl != pwm_lvl_q) || (omode_prev_q == TCC_OM_FROZEN)) begin
                    ref_d = pwm_lvl;  // [R19]
                end
                if (fast_hit) begin
                    ref_d = (omode == TCC_OM_PWM_TWO) ^ count_down;  // [R22]
                end
            end
        endcase
        if (!is_output) begin
            ref_d = 1'b0;
        end
        if (etr_clear) begin
            ref_d = 1'b0;  // [R15]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_q        <= 1'b0;
            pwm_lvl_q    <= 1'b0;
            omode_prev_q <= TCC_OM_FROZEN;
        end else begin
            ref_q        <= ref_d;
            pwm_lvl_q    <= pwm_lvl;
            omode_prev_q <= omode;
        end
    end

    // Read data one cycle after the strobe; event register always reads zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                STATUS_OFS:   rdata_q <= status_q;
                EVENT_OFS:    rdata_q <= 16'h0000;  // [R24]
                MODE_LOW_OFS: rdata_q <= mode_q;
                COMPARE0_OFS: rdata_q <= 16'(cmp_pre_q);
                default:      rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata              = rdata_q;
    assign chan0_output_reference = ref_q;
    assign chan0_capture_input    = cap_in_q;
    assign main_output_enable_clr = moe_clr_q;
    assign control_update_event   = com_ev_q;
    assign update_event           = upd_ev_q;
    assign counter_reload         = reload_q;
    assign counter_load_value     = load_val_q;
    assign status_flags           = status_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_strobe_selfclr: assert property (reg_wr && reg_addr == EVENT_OFS && reg_wdata[EV_UPDATE]  // [R6]
        |=> strobe_q[EV_UPDATE] ##1 (!strobe_q[EV_UPDATE] || $past(reg_wr))) else $error("strobe stuck");
    chk_break_event: assert property (strobe_q[EV_BREAK]  // [R7]
        |=> moe_clr_q && status_q[ST_BREAK]) else $error("break event lost");
    chk_trigger_flag: assert property (strobe_q[EV_TRIGGER] |=> status_q[ST_TRIGGER]) else  // [R8]
        $error("trigger flag not set");
    chk_control_gate: assert property (com_ev_q |-> $past(control_preload_select)  // [R9]
        && $past(strobe_q[EV_CONTROL])) else $error("control update without preload select");
    chk_update_soft: assert property (strobe_q[EV_UPDATE] && !update_source_restrict  // [R5]
        && !update_disable |=> status_q[ST_UPDATE] && reload_q) else $error("update flag missing");
    chk_sel_locked: assert property (wr_mode && chan0_enable  // [R14]
        |=> mode_q[1:0] == $past(mode_q[1:0])) else $error("selection changed while enabled");
    chk_overcapture: assert property (capture && status_q[ST_CHAN0]  // [R11]
        |=> status_q[ST_OVERCAP0] && cmp_act_q == $past(counter_value)) else $error("overcapture missed");
    chk_event_read: assert property (reg_rd && reg_addr == EVENT_OFS |=> reg_rdata == 16'h0000) else  // [R24]
        $error("event register read nonzero");
    chk_etr_clear: assert property (etr_clear |=> !chan0_output_reference) else  // [R15]
        $error("reference not cleared by trigger");
    chk_force_low: assert property (is_output && omode == TCC_OM_FORCE_L  // [R16]
        |=> !chan0_output_reference) else $error("forced low failed");

    cov_capture_ovc: cover property (capture && status_q[ST_CHAN0]);
    cov_pwm_toggle: cover property (omode == TCC_OM_PWM_ONE && ref_q ##1 !ref_q);
    cov_preload_xfer: cover property (upd_any && preload_on && cmp_act_q != cmp_pre_q);
endmodule // tcc_chan_ctrl

/* design/tcc_pkg.sv */
package tcc_pkg;
    // Register byte offsets
    localparam logic [7:0]  STATUS_OFS    = 8'h10;
    localparam logic [7:0]  EVENT_OFS     = 8'h14;
    localparam logic [7:0]  MODE_LOW_OFS  = 8'h18;
    localparam logic [7:0]  COMPARE0_OFS  = 8'h34;

    // Event strobe bit positions
    localparam int          EV_UPDATE     = 0;
    localparam int          EV_CHAN0      = 1;
    localparam int          EV_CONTROL    = 5;
    localparam int          EV_TRIGGER    = 6;
    localparam int          EV_BREAK      = 7;

    // Status bit positions
    localparam int          ST_UPDATE     = 0;
    localparam int          ST_CHAN0      = 1;
    localparam int          ST_CONTROL    = 5;
    localparam int          ST_TRIGGER    = 6;
    localparam int          ST_BREAK      = 7;
    localparam int          ST_OVERCAP0   = 9;

    // Channel mode field positions
    localparam int          MD_SEL_LSB    = 0;
    localparam int          MD_FAST       = 2;
    localparam int          MD_PRELOAD    = 3;
    localparam int          MD_MODE_LSB   = 4;
    localparam int          MD_CLEAR      = 7;
    localparam int          MD_SEL1_LSB   = 8;

    // Reset values
    localparam logic [15:0] MODE_RST      = 16'h0000;
    localparam logic [15:0] STATUS_RST    = 16'h0000;
    localparam logic [15:0] COMPARE_RST   = 16'h0000;

    // Trigger edge to output delay with fast enable, in cycles
    localparam int          FAST_TRIG_CYC = 3;

    typedef enum logic [1:0] {
        TCC_SEL_OUTPUT = 2'b00,
        TCC_SEL_IN_ONE = 2'b01,
        TCC_SEL_IN_TWO = 2'b10,
        TCC_SEL_IN_TRG = 2'b11
    } tcc_sel_t;

    typedef enum logic [2:0] {
        TCC_OM_FROZEN  = 3'b000,
        TCC_OM_SET     = 3'b001,
        TCC_OM_CLEAR   = 3'b010,
        TCC_OM_TOGGLE  = 3'b011,
        TCC_OM_FORCE_L = 3'b100,
        TCC_OM_FORCE_H = 3'b101,
        TCC_OM_PWM_ONE = 3'b110,
        TCC_OM_PWM_TWO = 3'b111
    } tcc_omode_t;
endpackage

/* sim/tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    import tcc_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, status_flags, rd_v, mode_m = 16'h0000, cmp, cv;
    logic [15:0] counter_value = 16'h0001, auto_reload_value = 16'hFFFF, counter_load_value;
    logic [1:0]  center_align_select = 2'b00;
    logic count_down = 0, counter_wrap = 0, rep_count_zero = 1, update_disable = 0, update_source_restrict = 0;
    logic trigger_reinit = 0, trigger_edge = 0, chan0_enable = 0, chan1_enable = 0, control_preload_select = 1;
    logic lock_level3 = 0, int_trig_selected = 0, capture_edge = 0, filtered_external_trigger = 0;
    logic timer_input_one = 1, timer_input_two = 0, internal_trigger_source = 1;
    logic chan0_output_reference, chan0_capture_input, main_output_enable_clr, control_update_event;
    logic update_event, counter_reload;
    int   mismatches = 0, n_compared = 0;

    tcc_chan_ctrl dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter_value(counter_value), .auto_reload_value(auto_reload_value),
        .count_down(count_down), .center_align_select(center_align_select), .counter_wrap(counter_wrap),
        .rep_count_zero(rep_count_zero), .update_disable(update_disable), .trigger_reinit(trigger_reinit),
        .update_source_restrict(update_source_restrict), .trigger_edge(trigger_edge), .chan0_enable(chan0_enable),
        .chan1_enable(chan1_enable), .control_preload_select(control_preload_select), .lock_level3(lock_level3),
        .int_trig_selected(int_trig_selected), .capture_edge(capture_edge), .timer_input_one(timer_input_one),
        .filtered_external_trigger(filtered_external_trigger), .timer_input_two(timer_input_two),
        .internal_trigger_source(internal_trigger_source), .chan0_output_reference(chan0_output_reference),
        .chan0_capture_input(chan0_capture_input), .main_output_enable_clr(main_output_enable_clr),
        .control_update_event(control_update_event), .update_event(update_event), .counter_reload(counter_reload),
        .counter_load_value(counter_load_value), .status_flags(status_flags));

    // Free-running kernel clock, 4 ns period
    always #2 mclk = ~mclk;

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge mclk); reg_wr <= 1'b0;
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk); reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Mode model: selection and output bits may be write-blocked
    task automatic mwr(input logic [15:0] d);
        logic [15:0] n;
        wr(MODE_LOW_OFS, d);
        n = d;
        if (chan0_enable) n[1:0] = mode_m[1:0];
        if (chan1_enable) n[9:8] = mode_m[9:8];
        if (lock_level3 && mode_m[1:0] == 2'b00) n[6:3] = mode_m[6:3];
        mode_m = n;
    endtask
    // Counter passes the compare value for one cycle
    task automatic match(input logic [15:0] v);
        @(posedge mclk); counter_value <= v;
        @(posedge mclk); counter_value <= v + 16'h0001;
        cyc(2);
    endtask
    task automatic pulse_wrap();
        @(posedge mclk); counter_wrap <= 1'b1;
        @(posedge mclk); counter_wrap <= 1'b0;
        cyc(3);
    endtask
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        complete_run();
    end

    initial begin
        void'($urandom(3902));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(EVENT_OFS);    `CHK(rd_v, 16'h0000)
        rd(MODE_LOW_OFS); `CHK(rd_v, MODE_RST)
        rd(8'h3C);        `CHK(rd_v, 16'h0000)
        // Software update in both directions; load value follows direction
        for (int i = 0; i < 2; i++) begin
            count_down <= i[0];
            cv = 16'($urandom_range(32'hFFFF));
            auto_reload_value <= cv;
            wr(EVENT_OFS, 16'h0001); cyc(1);
            `CHK(counter_reload, 1'b1)
            `CHK(update_event, 1'b1)
            `CHK(counter_load_value, (i == 1) ? cv : 16'h0000)
            rd(STATUS_OFS); `CHK(rd_v[ST_UPDATE], 1'b1)
            wr(STATUS_OFS, 16'h0000);
            rd(EVENT_OFS);  `CHK(rd_v, 16'h0000)
        end
        count_down <= 1'b0;
        auto_reload_value <= 16'hFFFF;
        // Restricted source: counter still reloads, flag stays clear
        update_source_restrict <= 1'b1;
        wr(EVENT_OFS, 16'h0001); cyc(1); `CHK(counter_reload, 1'b1)
        rd(STATUS_OFS); `CHK(rd_v[ST_UPDATE], 1'b0)
        update_source_restrict <= 1'b0;
        wr(EVENT_OFS, 16'h0000); cyc(1); `CHK(counter_reload, 1'b0)
        // Wrap with repetition at zero, update enabled then disabled
        for (int i = 0; i < 2; i++) begin
            update_disable <= i[0];
            wr(STATUS_OFS, 16'h0000);
            pulse_wrap();
            rd(STATUS_OFS); `CHK(rd_v[ST_UPDATE], ~i[0])
        end
        update_disable <= 1'b0;
        // Trigger reinit reloads at once and flags an update
        wr(STATUS_OFS, 16'h0000);
        @(posedge mclk); trigger_reinit <= 1'b1;
        @(posedge mclk); trigger_reinit <= 1'b0;
        cyc(0); `CHK(counter_reload, 1'b1)
        rd(STATUS_OFS); `CHK(rd_v[ST_UPDATE], 1'b1)
        // Break, trigger and control strobes
        for (int b = 5; b < 8; b++) begin
            wr(STATUS_OFS, 16'h0000);
            wr(EVENT_OFS, 16'h0001 << b); cyc(1);
            `CHK(main_output_enable_clr, 1'(b == EV_BREAK))
            `CHK(control_update_event, 1'(b == EV_CONTROL))
            wr(STATUS_OFS, 16'hFFFF);
            rd(STATUS_OFS); `CHK(rd_v[b], 1'b1)
        end
        wr(STATUS_OFS, 16'h0000);
        rd(STATUS_OFS); `CHK(rd_v, 16'h0000)
        `CHK(status_flags, 16'h0000)
        control_preload_select <= 1'b0;
        wr(EVENT_OFS, 16'h0001 << EV_CONTROL); cyc(1); `CHK(control_update_event, 1'b0)
        // Output compare modes on a random compare value
        cmp = 16'h0100 + 16'($urandom_range(32'h7E00));
        wr(COMPARE0_OFS, cmp);
        rd(COMPARE0_OFS); `CHK(rd_v, cmp)
        mwr(16'h0000); match(cmp); `CHK(chan0_output_reference, 1'b0)
        rd(STATUS_OFS); `CHK(rd_v[ST_CHAN0], 1'b1)
        for (int i = 0; i < 6; i++) begin
            mwr(16'((18'h2_C29B >> (15 - 3 * i)) & 18'h0_0007) << MD_MODE_LSB);
            match(cmp);
            `CHK(chan0_output_reference, ~i[0])
        end
        // External clear forces reference low only when enabled
        filtered_external_trigger <= 1'b1;
        mwr(16'h00D0); cyc(2); `CHK(chan0_output_reference, 1'b0)
        mwr(16'h0050); cyc(2); `CHK(chan0_output_reference, 1'b1)
        filtered_external_trigger <= 1'b0;
        // PWM levels around the compare value, both directions
        for (int i = 0; i < 4; i++) begin
            count_down <= i[0];
            mwr(16'h0000);
            counter_value <= cmp - 16'h0001;
            mwr(i[1] ? 16'h0078 : 16'h0068); cyc(2);
            `CHK(chan0_output_reference, ~i[1])
            counter_value <= cmp; cyc(2);
            `CHK(chan0_output_reference, i[0] ^ i[1])
        end
        count_down <= 1'b0;
        // Fast enable: trigger edge acts as a match three cycles later
        mwr(16'h0000);
        counter_value <= cmp - 16'h0001;
        mwr(16'h006C); cyc(2);
        @(posedge mclk); trigger_edge <= 1'b1;
        @(posedge mclk); trigger_edge <= 1'b0;
        cyc(FAST_TRIG_CYC); `CHK(chan0_output_reference, 1'b0)
        // Preloaded compare waits for an update event
        mwr(16'h0048);
        wr(COMPARE0_OFS, cmp + 16'h0040);
        mwr(16'h0018); match(cmp + 16'h0040); `CHK(chan0_output_reference, 1'b0)
        wr(EVENT_OFS, 16'h0001); match(cmp + 16'h0040); `CHK(chan0_output_reference, 1'b1)
        // Compare above reload flags on wrap
        mwr(16'h0000); wr(COMPARE0_OFS, 16'h0020);
        auto_reload_value <= 16'h0010;
        wr(STATUS_OFS, 16'h0000); pulse_wrap();
        rd(STATUS_OFS); `CHK(rd_v[ST_CHAN0], 1'b1)
        auto_reload_value <= 16'hFFFF;
        // Lock blocks output bits while channel is an output
        lock_level3 <= 1'b1;
        mwr(16'h0058); rd(MODE_LOW_OFS); `CHK(rd_v, mode_m)
        lock_level3 <= 1'b0;
        // Selection writes blocked while channels enabled
        chan0_enable <= 1'b1;
        chan1_enable <= 1'b1;
        mwr(16'h0101); rd(MODE_LOW_OFS); `CHK(rd_v, mode_m)
        chan0_enable <= 1'b0;
        chan1_enable <= 1'b0;
        // Input source decode
        for (int i = 0; i < 4; i++) begin
            int_trig_selected <= (i == 3);
            mwr(16'(i < 3 ? i + 1 : 3));
            cyc(5); `CHK(chan0_capture_input, 1'(i == 0 || i == 3))
        end
        rd(MODE_LOW_OFS); `CHK(rd_v, mode_m)
        // Software capture twice gives overcapture; compare read clears flag
        wr(STATUS_OFS, 16'h0000);
        cv = 16'($urandom_range(32'hFFFF));
        counter_value <= cv;
        wr(EVENT_OFS, 16'h0002); cyc(3);
        rd(STATUS_OFS); `CHK({rd_v[ST_OVERCAP0], rd_v[ST_CHAN0]}, 2'b01)
        wr(EVENT_OFS, 16'h0002); cyc(3);
        rd(STATUS_OFS); `CHK({rd_v[ST_OVERCAP0], rd_v[ST_CHAN0]}, 2'b11)
        rd(COMPARE0_OFS); `CHK(rd_v, cv)
        rd(STATUS_OFS); `CHK(rd_v[ST_CHAN0], 1'b0)
        // Hardware capture edge
        counter_value <= cv ^ 16'h5A5A;
        @(posedge mclk); capture_edge <= 1'b1;
        @(posedge mclk); capture_edge <= 1'b0;
        cyc(2);
        rd(STATUS_OFS); `CHK(rd_v[ST_CHAN0], 1'b1)
        rd(COMPARE0_OFS); `CHK(rd_v, cv ^ 16'h5A5A)
        complete_run();
    end
endmodule // tb_top
